// file: core/glue_map.svh
// Overview of operation
// - only the host reaches the dynamic memory
// - both processors share static RAM through arbiter
// - co-processor held in reset while control reads 0
// - arbiter on: shared access, host cycle six clocks
// - arbiter off: host only, four clock cycles
// - host dynamic memory cycle always four clocks
// - co-processor write drives host event request level
// - co-processor read returns host acknowledge level
`ifndef GLUE_MAP_SVH
`define GLUE_MAP_SVH
// host word address, region in bits [23:22]
`define HOST_REGION_MSB   23
`define HOST_REGION_LSB   22
`define HOST_REGION_DRAM  2'h0
`define HOST_REGION_SRAM  2'h1
`define HOST_REGION_CTRL  2'h2
// control word indices within the control region
`define CTRL_IDX_COP_RESET 4'h0
`define CTRL_IDX_ARB_SEL   4'h1
// co-processor word address, bit 23 selects event location
`define COP_EVENT_BIT     23
// reset values
`define RST_COP_RESET     1'h0
`define RST_ARB_SEL       1'h1
`define RST_EVENT_REQ     1'h0
// cycle counts
`define HOST_DRAM_CYCLES  4
`define HOST_SRAM_CYCLES  4
`define COP_SRAM_CYCLES   4
`endif

// file: core/glue_pkg.sv
package glue_pkg;
	typedef enum logic [2:0] {
		H_IDLE,
		H_DRAM,
		H_CTRL,
		H_WAIT,
		H_SRAM
	} host_phase_t;
	typedef enum logic [1:0] {
		C_IDLE,
		C_WAIT,
		C_SRAM,
		C_EVENT
	} cop_phase_t;
	typedef enum logic [1:0] {
		OWN_NONE,
		OWN_HOST,
		OWN_COP
	} arb_owner_t;
	typedef struct packed {
		arb_owner_t owner;
		logic       last_host;
	} arb_state_t;
endpackage : glue_pkg

// file: core/sram_arb_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sram_arb_if;
	logic enable;
	logic host_req;
	logic cop_req;
	logic host_done;
	logic cop_done;
	logic host_grant;
	logic cop_grant;
	modport arb (input enable, host_req, cop_req, host_done, cop_done, output host_grant, cop_grant);
	modport ctl (output enable, host_req, cop_req, host_done, cop_done, input host_grant, cop_grant);
endinterface : sram_arb_if
`default_nettype wire

// file: core/sram_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module sram_arbiter (
	// clock and reset
	input  wire logic core_clk_in,
	input  wire logic arst_n_in,
	// requests and grants
	sram_arb_if.arb   arb
);
	import glue_pkg::*;
	arb_state_t state;
	arb_state_t next_state;

	always_comb begin
		next_state = state;
		case (state.owner)
			OWN_HOST: begin
				if (arb.host_done) next_state.owner = OWN_NONE;
			end
			OWN_COP: begin
				if (arb.cop_done) next_state.owner = OWN_NONE;
			end
			OWN_NONE: begin
				// co-processor only while enabled, and against a host request only if the host had the last grant
				if (arb.host_req && !(arb.cop_req && arb.enable && state.last_host)) begin
					next_state.owner = OWN_HOST;
					next_state.last_host = 1'h1;
				end else if (arb.cop_req && arb.enable && !arb.host_req) begin
					next_state.owner = OWN_COP;
					next_state.last_host = 1'h0;
				end else if (arb.cop_req && arb.enable && state.last_host) begin
					next_state.owner = OWN_COP;
					next_state.last_host = 1'h0;
				end
			end
			default: next_state.owner = OWN_NONE;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= '{owner: OWN_NONE, last_host: 1'h0};
		end else begin
			state <= next_state;
		end
	end

	assign arb.host_grant = (state.owner == OWN_HOST);
	assign arb.cop_grant  = (state.owner == OWN_COP);
endmodule : sram_arbiter
`default_nettype wire

// file: core/shared_sram_vector_module_glue.sv
`timescale 1ns/100ps
`default_nettype none
`include "glue_map.svh"
module shared_sram_vector_module_glue #(
	parameter int HOST_AW = 24,
	parameter int COP_AW  = 24,
	parameter int DW      = 32,
	parameter int SRAM_AW = 16,
	parameter int DRAM_AW = 18
) (
	// clock and reset
	input  wire logic               core_clk_in,
	input  wire logic               arst_n_in,
	// host access port
	input  wire logic               host_req_in,
	input  wire logic               host_we_in,
	input  wire logic [HOST_AW-1:0] host_addr_in,
	input  wire logic [DW-1:0]      host_wdata_in,
	output logic                    host_ack_out,
	output logic [DW-1:0]           host_rdata_out,
	// co-processor access port
	input  wire logic               cop_req_in,
	input  wire logic               cop_we_in,
	input  wire logic [COP_AW-1:0]  cop_addr_in,
	input  wire logic [DW-1:0]      cop_wdata_in,
	output logic                    cop_ack_out,
	output logic [DW-1:0]           cop_rdata_out,
	// dynamic memory, host only
	output logic                    dram_cs_out,
	output logic                    dram_we_out,
	output logic [DRAM_AW-1:0]      dram_addr_out,
	output logic [DW-1:0]           dram_wdata_out,
	input  wire logic [DW-1:0]      dram_rdata_in,
	// shared static RAM
	output logic                    sram_cs_out,
	output logic                    sram_we_out,
	output logic [SRAM_AW-1:0]      sram_addr_out,
	output logic [DW-1:0]           sram_wdata_out,
	input  wire logic [DW-1:0]      sram_rdata_in,
	// control and signalling
	output logic                    cop_reset_n_out,
	output logic                    arb_enabled_out,
	output logic                    host_event_req_out,
	input  wire logic               host_signal_ack_in
);
	import glue_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// elaboration checks
	generate
		if (HOST_AW <= `HOST_REGION_MSB || COP_AW <= `COP_EVENT_BIT || SRAM_AW > HOST_AW - 2
				|| SRAM_AW > COP_AW - 1 || DRAM_AW > HOST_AW - 2 || DW < 2) begin : g_bad
			$error("address or data widths not supported");
		end
	endgenerate

	typedef struct packed {
		host_phase_t        hph;
		logic [3:0]         hcnt;
		logic               hwe;
		logic [HOST_AW-1:0] haddr;
		logic [DW-1:0]      hwdata;
		logic               hack;
		logic [DW-1:0]      hrdata;
		cop_phase_t         cph;
		logic [3:0]         ccnt;
		logic               cwe;
		logic [COP_AW-1:0]  caddr;
		logic [DW-1:0]      cwdata;
		logic               cack;
		logic [DW-1:0]      crdata;
		logic               cop_reset;
		logic               arb_sel;
		logic               event_req;
		logic               dcs;
		logic               dwe;
		logic [DRAM_AW-1:0] daddr;
		logic [DW-1:0]      dwdata;
		logic               scs;
		logic               swe;
		logic [SRAM_AW-1:0] saddr;
		logic [DW-1:0]      swdata;
	} glue_state_t;

	localparam logic [3:0] HOST_DRAM_N = 4'(`HOST_DRAM_CYCLES);
	localparam logic [3:0] HOST_SRAM_N = 4'(`HOST_SRAM_CYCLES);
	localparam logic [3:0] COP_SRAM_N  = 4'(`COP_SRAM_CYCLES);

	glue_state_t state;
	glue_state_t next_state;
	sram_arb_if  arb_bus ();

	sram_arbiter u_arbiter (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.arb         (arb_bus.arb)
	);

	assign arb_bus.enable    = state.arb_sel;
	assign arb_bus.host_req  = (state.hph == H_WAIT) || (state.hph == H_SRAM);
	assign arb_bus.cop_req   = (state.cph == C_WAIT) || (state.cph == C_SRAM);
	assign arb_bus.host_done = state.hack && (state.hph == H_IDLE) && arb_bus.host_grant;
	// a grant cut short by co-processor reset is released too, or the arbiter locks up
	assign arb_bus.cop_done  = arb_bus.cop_grant && (state.cph == C_IDLE) && (state.cack || !state.cop_reset);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [1:0] region;
		logic [3:0] ctrl_idx;
		region = 2'h0;
		ctrl_idx = 4'h0;
		next_state = state;
		next_state.hack = 1'h0;
		next_state.cack = 1'h0;

		// host side
		case (state.hph)
			H_IDLE: begin
				if (host_req_in) begin
					region = host_addr_in[`HOST_REGION_MSB:`HOST_REGION_LSB];
					ctrl_idx = host_addr_in[3:0];
					next_state.hwe = host_we_in;
					next_state.haddr = host_addr_in;
					next_state.hwdata = host_wdata_in;
					next_state.hcnt = 4'h1;
					if (region == `HOST_REGION_DRAM) begin
						next_state.hph = H_DRAM;
					end else if (region == `HOST_REGION_SRAM) begin
						// arbiter off and no co-processor grant: straight in
						if (!state.arb_sel && !arb_bus.cop_grant) next_state.hph = H_SRAM;
						else next_state.hph = H_WAIT;
					end else begin
						next_state.hph = H_CTRL;
						if (host_we_in && region == `HOST_REGION_CTRL) begin
							if (ctrl_idx == `CTRL_IDX_COP_RESET) next_state.cop_reset = host_wdata_in[0];
							if (ctrl_idx == `CTRL_IDX_ARB_SEL) next_state.arb_sel = host_wdata_in[0];
						end
					end
				end
			end
			H_DRAM, H_CTRL: begin
				next_state.hcnt = state.hcnt + 4'h1;
				if (state.hcnt == HOST_DRAM_N) begin
					next_state.hph = H_IDLE;
					next_state.hack = 1'h1;
					next_state.hrdata = (state.hph == H_DRAM) ? dram_rdata_in : '0;
				end
			end
			H_WAIT: begin
				if (arb_bus.host_grant) begin
					next_state.hph = H_SRAM;
					next_state.hcnt = 4'h1;
				end
			end
			H_SRAM: begin
				next_state.hcnt = state.hcnt + 4'h1;
				if (state.hcnt == HOST_SRAM_N) begin
					next_state.hph = H_IDLE;
					next_state.hack = 1'h1;
					next_state.hrdata = sram_rdata_in;
				end
			end
			default: next_state.hph = H_IDLE;
		endcase

		// co-processor side, forced to C_IDLE while held in reset
		case (state.cph)
			C_IDLE: begin
				if (cop_req_in && state.cop_reset) begin
					next_state.cwe = cop_we_in;
					next_state.caddr = cop_addr_in;
					next_state.cwdata = cop_wdata_in;
					next_state.ccnt = 4'h1;
					if (cop_addr_in[`COP_EVENT_BIT]) begin
						next_state.cph = C_EVENT;
						if (cop_we_in) next_state.event_req = cop_wdata_in[0];
					end else begin
						next_state.cph = C_WAIT;
					end
				end
			end
			C_EVENT: begin
				next_state.cph = C_IDLE;
				next_state.cack = 1'h1;
				next_state.crdata = {{(DW-1){1'b0}}, host_signal_ack_in};
			end
			C_WAIT: begin
				if (arb_bus.cop_grant) begin
					next_state.cph = C_SRAM;
					next_state.ccnt = 4'h1;
				end
			end
			C_SRAM: begin
				next_state.ccnt = state.ccnt + 4'h1;
				if (state.ccnt == COP_SRAM_N) begin
					next_state.cph = C_IDLE;
					next_state.cack = 1'h1;
					next_state.crdata = sram_rdata_in;
				end
			end
			default: next_state.cph = C_IDLE;
		endcase
		if (!state.cop_reset) begin
			next_state.cph = C_IDLE;
			next_state.cack = 1'h0;
		end

		// memory strobes follow the phase about to be entered
		next_state.dcs = (next_state.hph == H_DRAM);
		next_state.dwe = (next_state.hph == H_DRAM) && next_state.hwe;
		next_state.daddr = next_state.haddr[DRAM_AW-1:0];
		next_state.dwdata = next_state.hwdata;
		if (next_state.hph == H_SRAM) begin
			next_state.scs = 1'h1;
			next_state.swe = next_state.hwe;
			next_state.saddr = next_state.haddr[SRAM_AW-1:0];
			next_state.swdata = next_state.hwdata;
		end else if (next_state.cph == C_SRAM) begin
			next_state.scs = 1'h1;
			next_state.swe = next_state.cwe;
			next_state.saddr = next_state.caddr[SRAM_AW-1:0];
			next_state.swdata = next_state.cwdata;
		end else begin
			next_state.scs = 1'h0;
			next_state.swe = 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= '0;
			state.hph <= H_IDLE;
			state.cph <= C_IDLE;
			state.cop_reset <= `RST_COP_RESET;
			state.arb_sel <= `RST_ARB_SEL;
			state.event_req <= `RST_EVENT_REQ;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign host_ack_out       = state.hack;
	assign host_rdata_out     = state.hrdata;
	assign cop_ack_out        = state.cack;
	assign cop_rdata_out      = state.crdata;
	assign dram_cs_out        = state.dcs;
	assign dram_we_out        = state.dwe;
	assign dram_addr_out      = state.daddr;
	assign dram_wdata_out     = state.dwdata;
	assign sram_cs_out        = state.scs;
	assign sram_we_out        = state.swe;
	assign sram_addr_out      = state.saddr;
	assign sram_wdata_out     = state.swdata;
	assign cop_reset_n_out    = state.cop_reset;
	assign arb_enabled_out    = state.arb_sel;
	assign host_event_req_out = state.event_req;
endmodule : shared_sram_vector_module_glue
`default_nettype wire

// file: bench/glue_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "glue_map.svh"
module glue_assertions #(
	parameter int DW      = 32,
	parameter int HOST_AW = 24,
	parameter int COP_AW  = 24
) (
	// clock and reset
	input wire logic               core_clk_in,
	input wire logic               arst_n_in,
	// host side
	input wire logic               host_req_in,
	input wire logic               host_we_in,
	input wire logic [HOST_AW-1:0] host_addr_in,
	input wire logic [DW-1:0]      host_wdata_in,
	input wire logic               host_ack_out,
	// co-processor side
	input wire logic               cop_req_in,
	input wire logic               cop_we_in,
	input wire logic [COP_AW-1:0]  cop_addr_in,
	input wire logic [DW-1:0]      cop_wdata_in,
	input wire logic               cop_ack_out,
	input wire logic [DW-1:0]      cop_rdata_out,
	// memories and control
	input wire logic               dram_cs_out,
	input wire logic               sram_cs_out,
	input wire logic               cop_reset_n_out,
	input wire logic               arb_enabled_out,
	input wire logic               host_event_req_out,
	input wire logic               host_signal_ack_in
);
	logic [1:0] region;
	logic       ctl_wr;
	logic       ev_wr;
	assign region = host_addr_in[`HOST_REGION_MSB:`HOST_REGION_LSB];
	assign ctl_wr = host_req_in && host_we_in && region == `HOST_REGION_CTRL;
	assign ev_wr  = cop_req_in && cop_addr_in[`COP_EVENT_BIT];
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	////////////////////////////////////////////////////////////////
	sequence s_dram_cyc;
		dram_cs_out[*4] ##1 (!dram_cs_out && host_ack_out);
	endsequence
	sequence s_sram_cyc;
		sram_cs_out[*4] ##1 !sram_cs_out;
	endsequence
	a_dram_cycle: assert property ($rose(dram_cs_out) |-> s_dram_cyc)
		else $error("dram cycle length wrong");
	a_dram_owner: assert property ($rose(dram_cs_out) |-> $past(host_req_in && region == `HOST_REGION_DRAM))
		else $error("dram cycle without host request");
	a_sram_grant: assert property ($rose(sram_cs_out) |-> s_sram_cyc)
		else $error("sram grant not held for cycle");
	a_event_req: assert property ($rose(cop_ack_out) && $past(ev_wr && cop_we_in, 2)
		|-> host_event_req_out == $past(cop_wdata_in[0], 2)) else $error("event request level wrong");
	a_event_read: assert property ($rose(cop_ack_out) && $past(ev_wr && !cop_we_in, 2)
		|-> cop_rdata_out == DW'($past(host_signal_ack_in))) else $error("event read wrong");
	a_reset_ctl: assert property ($changed(cop_reset_n_out) |-> $past(ctl_wr && host_addr_in[3:0] ==
		`CTRL_IDX_COP_RESET) && cop_reset_n_out == $past(host_wdata_in[0])) else $error("reset control wrong");
	a_arb_ctl: assert property ($changed(arb_enabled_out) |-> $past(ctl_wr && host_addr_in[3:0] ==
		`CTRL_IDX_ARB_SEL) && arb_enabled_out == $past(host_wdata_in[0])) else $error("arbiter select wrong");
	a_held_quiet: assert property (!cop_reset_n_out && !$past(cop_reset_n_out) |-> !cop_ack_out)
		else $error("co-processor served while held");
endmodule : glue_assertions
bind shared_sram_vector_module_glue glue_assertions #(.DW(DW), .HOST_AW(HOST_AW), .COP_AW(COP_AW)) chk_u (
	.core_clk_in, .arst_n_in, .host_req_in, .host_we_in, .host_addr_in, .host_wdata_in, .host_ack_out,
	.cop_req_in, .cop_we_in, .cop_addr_in, .cop_wdata_in, .cop_ack_out, .cop_rdata_out, .dram_cs_out,
	.sram_cs_out, .cop_reset_n_out, .arb_enabled_out, .host_event_req_out, .host_signal_ack_in);
`default_nettype wire

// file: bench/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	// clock
	input  wire logic        clk_in,
	// memory strobes
	input  wire logic        cs_in,
	input  wire logic        we_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	output logic [31:0]      rdata_out
);
	logic [31:0] mem [256];
	logic [31:0] last = 32'h0;
	always @(posedge clk_in) begin
		if (cs_in && we_in)
			mem[addr_in] <= wdata_in;
		if (cs_in)
			last <= mem[addr_in];
	end
	// released bus shows inverted last value
	assign rdata_out = cs_in ? mem[addr_in] : ~last;
endmodule : mem_model
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic core_clk_in = 1'h0, arst_n_in = 1'h0, host_req_in = 1'h0, host_we_in = 1'h0;
	logic cop_req_in = 1'h0, cop_we_in = 1'h0, host_signal_ack_in = 1'h0;
	logic [23:0] host_addr_in = 24'h0, cop_addr_in = 24'h0;
	logic [31:0] host_wdata_in = 32'h0, cop_wdata_in = 32'h0, host_rdata_out, cop_rdata_out, rd, rd2;
	logic [31:0] dram_rdata_in, sram_rdata_in, dram_wdata_out, sram_wdata_out;
	logic [17:0] dram_addr_out;
	logic [15:0] sram_addr_out;
	logic host_ack_out, cop_ack_out, dram_cs_out, dram_we_out, sram_cs_out, sram_we_out;
	logic cop_reset_n_out, arb_enabled_out, host_event_req_out;
	int error_cnt = 0, comparisons = 0, cyc = 0, lat, lat2;
	// co-processor figures
	localparam int COP_DW        = 32;
	localparam int COP_AW        = 24;
	localparam int FETCH_WORDS   = 4;
	localparam int FETCH_BITS    = 64;
	localparam int IRAM_BYTES    = 512;
	localparam int IRAM_CPLX     = 64;
	localparam bit VEC_FIFO_USED = 1'b1;
	localparam int ACC_BITS      = 44;
	localparam int INT_BITS      = 24;
	shared_sram_vector_module_glue dut_u (.core_clk_in, .arst_n_in, .host_req_in, .host_we_in, .host_addr_in,
		.host_wdata_in, .host_ack_out, .host_rdata_out, .cop_req_in, .cop_we_in, .cop_addr_in, .cop_wdata_in,
		.cop_ack_out, .cop_rdata_out, .dram_cs_out, .dram_we_out, .dram_addr_out, .dram_wdata_out, .dram_rdata_in,
		.sram_cs_out, .sram_we_out, .sram_addr_out, .sram_wdata_out, .sram_rdata_in, .cop_reset_n_out,
		.arb_enabled_out, .host_event_req_out, .host_signal_ack_in);
	mem_model dram_u (.clk_in(core_clk_in), .cs_in(dram_cs_out), .we_in(dram_we_out),
		.addr_in(dram_addr_out[7:0]), .wdata_in(dram_wdata_out), .rdata_out(dram_rdata_in));
	mem_model sram_u (.clk_in(core_clk_in), .cs_in(sram_cs_out), .we_in(sram_we_out),
		.addr_in(sram_addr_out[7:0]), .wdata_in(sram_wdata_out), .rdata_out(sram_rdata_in));
	always #12.5 core_clk_in = ~core_clk_in;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// request dropped after take edge; n is edges from take to ack
	task automatic acc(input bit cop, input logic we, input logic [23:0] a, input logic [31:0] d,
		output int n, output logic [31:0] r);
		@(posedge core_clk_in);
		#1 if (cop) {cop_req_in, cop_we_in, cop_addr_in, cop_wdata_in} = {1'h1, we, a, d};
		else {host_req_in, host_we_in, host_addr_in, host_wdata_in} = {1'h1, we, a, d};
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1 if (cop) cop_req_in = 1'h0;
			else host_req_in = 1'h0;
			n++;
		end while ((cop ? cop_ack_out : host_ack_out) !== 1'h1 && n < 20);
		n--;
		r = cop ? cop_rdata_out : host_rdata_out;
	endtask : acc
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge core_clk_in);
		#1 arst_n_in = 1'h1;
		chk(cop_reset_n_out, 32'h0);
		chk(host_event_req_out, 32'h0);
		acc(1, 1'h0, 24'h000030, 32'h0, lat, rd);
		chk(lat, 32'h13);
		acc(0, 1'h1, 24'h800000, 32'h1, lat, rd);
		chk(cop_reset_n_out, 32'h1);
		for (int k = 1; k >= 0; k--) begin
			acc(0, 1'h1, 24'h800001, k, lat, rd);
			chk(arb_enabled_out, k);
			acc(0, 1'h1, 24'h000010 + k, 32'hA5A50000 + k, lat, rd);
			chk(lat, 32'h4);
			acc(0, 1'h0, 24'h000010 + k, 32'h0, lat, rd);
			chk(rd, 32'hA5A50000 + k);
			acc(0, 1'h1, 24'h400020 + k, 32'h5A5A0000 + k, lat, rd);
			chk(lat, k ? 32'h6 : 32'h4);
			acc(0, 1'h0, 24'h400020 + k, 32'h0, lat, rd);
			chk(rd, 32'h5A5A0000 + k);
		end
		acc(0, 1'h1, 24'h800001, 32'h1, lat, rd);
		acc(1, 1'h0, 24'h000021, 32'h0, lat, rd);
		chk(rd, 32'h5A5A0001);
		chk(lat, 32'h6);
		for (int k = 1; k >= 0; k--) begin
			acc(1, 1'h1, 24'h800000, k, lat, rd);
			chk(host_event_req_out, k);
			host_signal_ack_in = k[0];
			acc(1, 1'h0, 24'h800000, 32'h0, lat, rd);
			chk(rd, k);
		end
		fork
			acc(1, 1'h1, 24'h000030, 32'hC0DE0001, lat, rd);
			acc(0, 1'h1, 24'h400031, 32'hC0DE0002, lat2, rd2);
		join
		chk(lat + lat2 > 12, 32'h1);
		acc(0, 1'h0, 24'h400030, 32'h0, lat, rd);
		chk(rd, 32'hC0DE0001);
		acc(1, 1'h0, 24'h000031, 32'h0, lat, rd);
		chk(rd, 32'hC0DE0002);
		// host loads one instruction queue worth, co-processor fetches it
		for (int i = 0; i < FETCH_WORDS * FETCH_BITS / COP_DW; i++) begin
			acc(0, 1'h1, 24'h400040 + i, 32'hF0E00000 + i, lat, rd);
		end
		for (int i = 0; i < FETCH_WORDS * FETCH_BITS / COP_DW; i++) begin
			acc(1, 1'h0, 24'h000040 + i, 32'h0, lat, rd);
			chk(rd, 32'hF0E00000 + i);
		end
		// reset lands while the co-processor waits for its grant
		fork
			acc(1, 1'h1, 24'h000050, 32'h0, lat2, rd2);
			acc(0, 1'h1, 24'h800000, 32'h0, lat, rd);
		join
		chk(cop_reset_n_out, 32'h0);
		chk(lat2, 32'h13);
		acc(0, 1'h0, 24'h400030, 32'h0, lat, rd);
		chk(lat, 32'h6);
		chk(rd, 32'hC0DE0001);
		repeat (40) @(posedge core_clk_in);
		acc(1, 1'h0, 24'h000030, 32'h0, lat, rd);
		chk(lat, 32'h13);
		acc(0, 1'h1, 24'h800000, 32'h1, lat, rd);
		chk(cop_reset_n_out, 32'h1);
		results();
	end
endmodule : tb
`default_nettype wire
